// *** logic/csd_consts.vh ***
// Constants for the channel sequencer instruction decoder.
// Assumes inclusion by the decoder module only; definitions only.
`ifndef CSD_CONSTS_VH
`define CSD_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CSD_REG_CTRL 8'h00
`define CSD_REG_STATUS 8'h04
`define CSD_REG_MEM_ADDR 8'h08
`define CSD_REG_MEM_DATA 8'h0C
`define CSD_REG_TARGET 8'h10
`define CSD_REG_VMEAS 8'h14
`define CSD_REG_PC 8'h18
`define CSD_REG_TIME_LIMIT 8'h1C

// ****************************************************************
// Control register fields
// ****************************************************************
`define CSD_CTRL_START 0
`define CSD_CTRL_AUTO 1
`define CSD_CTRL_STOP 2

// ****************************************************************
// Header low byte fields
// ****************************************************************
`define CSD_H_CLASS_LO 0
`define CSD_H_VOLT 2
`define CSD_H_CURR 3
`define CSD_H_POW 4
`define CSD_H_RES 5
`define CSD_H_LIMOFF 6
`define CSD_H_ASYNC 7

// ****************************************************************
// Header high byte fields
// ****************************************************************
`define CSD_H_RAMP 8
`define CSD_H_SWITCH 9
`define CSD_H_RHEAD 10
`define CSD_H_RTAIL 11
`define CSD_H_VSRC 12
`define CSD_H_GAIN 13
`define CSD_H_IRQ 14
`define CSD_H_TFAULT 15

// ****************************************************************
// Instruction classes and reset values
// ****************************************************************
`define CSD_CLASS_HALT 2'h0
`define CSD_CLASS_REST 2'h1
`define CSD_RELATIVE_BIT 15
`define CSD_PC_RESET 7'h00

// ****************************************************************
// Timing: time limit tick of 1 us at 250 MHz
// ****************************************************************
`define CSD_TICK_NS 1000
`define CSD_CLK_NS 4
`define CSD_TICK_CYCLES (`CSD_TICK_NS / `CSD_CLK_NS)

`endif

// *** logic/csd_decoder.v ***
// Instruction decoder and executor for one battery channel sequencer.
// Assumes an AHB-Lite master with single word transfers and a
// measurement path that supplies the latest voltage reading.
//
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "csd_consts.vh"

module csd_decoder #(
    parameter MEM_DEPTH = 128,
    parameter AW = 7,
    parameter [1:0] CHARGE_CODE = 2'h2,
    parameter [15:0] TICK_CYCLES = `CSD_TICK_CYCLES
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire loop_high_side,
    input wire loop_low_side,
    output reg high_side_drive,
    output reg low_side_drive,
    output reg switch_pin_level,
    output reg loop_hold,
    output reg measure_run,
    output reg auto_async_rectify_en,
    output reg limit_check_off,
    output reg [3:0] mode_flags,
    output reg discharge,
    output reg time_limit_is_fault,
    output reg loop_gain_bank,
    output reg voltage_source_sel,
    output reg ramp_en,
    output reg done_irq_req,
    output reg program_finished,
    output reg instr_timeout
);

// ****************************************************************
// Declarations
// ****************************************************************
localparam ST_IDLE = 3'h0;
localparam ST_HDR = 3'h1;
localparam ST_PAY = 3'h2;
localparam ST_EXEC = 3'h3;
localparam ST_HALT = 3'h4;

reg [15:0] mem [0:MEM_DEPTH-1];
reg [2:0] state;
reg [AW-1:0] pc;
reg [AW-1:0] fetch;
reg [AW-1:0] head_addr;
reg [7:0] repeat_total;
reg [15:0] hdr;
reg [2:0] pay_idx;
reg [15:0] time_limit;
reg [15:0] tick_cnt;
reg [15:0] time_cnt;
reg auto_mode;
reg [AW-1:0] mem_addr;
reg [15:0] current_target;
reg [15:0] voltage_target;
reg [15:0] power_target;
reg [15:0] conductance_target;
reg [15:0] current_end_level;
reg [15:0] voltage_gate_level;
reg [15:0] vmeas;
reg ap_write;
reg ap_valid;
reg [7:0] ap_addr;
wire [15:0] word;
wire [1:0] instruction_class;
wire [7:0] pay_mask;
wire time_up;
wire [15:0] rel_v;

// Payload slot enable per header: slots 0..7 as in the charge layout
function [7:0] csd_slots;
    input [15:0] h;
    begin
        if (h[1:0] == `CSD_CLASS_REST) begin
            csd_slots = {h[`CSD_H_RHEAD], 1'b1, 6'h00};
        end else begin
            csd_slots = {h[`CSD_H_RHEAD], 1'b1, h[`CSD_H_CURR],
                h[`CSD_H_VOLT], h[`CSD_H_RES], h[`CSD_H_POW],
                h[`CSD_H_VOLT], h[`CSD_H_CURR]};
        end
    end
endfunction

// Count of enabled payload words
function [AW-1:0] csd_count;
    input [7:0] m;
    integer i;
    begin
        csd_count = {AW{1'b0}};
        for (i = 0; i < 8; i = i + 1) begin
            csd_count = csd_count + {{(AW-1){1'b0}}, m[i]};
        end
    end
endfunction

// Lowest enabled slot at or above a start index
function [2:0] csd_next;
    input [7:0] m;
    input [2:0] s;
    integer i;
    reg found;
    begin
        found = 1'b0;
        csd_next = 3'h7;
        for (i = 0; i < 8; i = i + 1) begin
            if (!found && i >= s && m[i]) begin
                csd_next = i[2:0];
                found = 1'b1;
            end
        end
    end
endfunction

assign word = mem[fetch];
assign instruction_class = hdr[1:0];
assign pay_mask = csd_slots(hdr);
assign time_up = (time_cnt >= time_limit);
assign rel_v = vmeas + {1'b0, word[14:0]};

// ****************************************************************
// AHB-Lite slave
// ****************************************************************
// Address phase capture; zero wait state once out of reset, always OKAY response
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ap_valid <= 1'b0;
        ap_write <= 1'b0;
        ap_addr <= 8'h00;
        hreadyout <= 1'b0;
        hresp <= 1'b0;
    end else begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        if (hready) begin
            ap_valid <= hsel && htrans[1];
            ap_write <= hwrite;
            ap_addr <= haddr[7:0];
        end
    end
end

// Read data for the next data phase; unmapped reads as zero
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
        case (haddr[7:0])
            `CSD_REG_CTRL: hrdata <= {30'h0, auto_mode, 1'b0};
            `CSD_REG_STATUS: hrdata <= {26'h0, instr_timeout,
                program_finished, 1'b0, state};
            `CSD_REG_MEM_ADDR: hrdata <= {{(32-AW){1'b0}}, mem_addr};
            `CSD_REG_MEM_DATA: hrdata <= {16'h0, mem[mem_addr]};
            `CSD_REG_TARGET: hrdata <= {voltage_target, current_target};
            `CSD_REG_VMEAS: hrdata <= {16'h0, vmeas};
            `CSD_REG_PC: hrdata <= {8'h0, repeat_total,
                {(16-AW){1'b0}}, pc};
            `CSD_REG_TIME_LIMIT: hrdata <= {time_cnt, time_limit};
            default: hrdata <= 32'h00000000;
        endcase
    end
end

// Instruction memory written by the host
always @(posedge hclk) begin
    if (ap_valid && ap_write && ap_addr == `CSD_REG_MEM_DATA) begin
        mem[mem_addr] <= hwdata[15:0];
    end
end

// Memory pointer, auto-increments after each data write
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        mem_addr <= {AW{1'b0}};
        auto_mode <= 1'b0;
        vmeas <= 16'h0000;
    end else if (ap_valid && ap_write) begin
        if (ap_addr == `CSD_REG_MEM_ADDR) begin
            mem_addr <= hwdata[AW-1:0];
        end else if (ap_addr == `CSD_REG_MEM_DATA) begin
            mem_addr <= mem_addr + {{(AW-1){1'b0}}, 1'b1};
        end else if (ap_addr == `CSD_REG_CTRL) begin
            auto_mode <= hwdata[`CSD_CTRL_AUTO];
        end else if (ap_addr == `CSD_REG_VMEAS) begin
            vmeas <= hwdata[15:0];
        end
    end
end

// ****************************************************************
// Sequencer
// ****************************************************************
// Fetch, payload parse, execute and loop control
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        state <= ST_IDLE;
        pc <= `CSD_PC_RESET;
        fetch <= `CSD_PC_RESET;
        head_addr <= `CSD_PC_RESET;
        repeat_total <= 8'h00;
        hdr <= 16'h0000;
        pay_idx <= 3'h0;
        time_limit <= 16'h0000;
        tick_cnt <= 16'h0000;
        time_cnt <= 16'h0000;
        current_target <= 16'h0000;
        voltage_target <= 16'h0000;
        power_target <= 16'h0000;
        conductance_target <= 16'h0000;
        current_end_level <= 16'h0000;
        voltage_gate_level <= 16'h0000;
        program_finished <= 1'b0;
        instr_timeout <= 1'b0;
    end else if (ap_valid && ap_write && ap_addr == `CSD_REG_CTRL
            && hwdata[`CSD_CTRL_STOP]) begin
        state <= ST_IDLE;
    end else if (ap_valid && ap_write && ap_addr == `CSD_REG_CTRL
            && hwdata[`CSD_CTRL_START]) begin
        pc <= `CSD_PC_RESET;
        fetch <= `CSD_PC_RESET;
        repeat_total <= 8'h00;
        program_finished <= 1'b0;
        instr_timeout <= 1'b0;
        state <= ST_HDR;
    end else begin
        case (state)
            ST_HDR: begin
                hdr <= word;
                pay_idx <= 3'h0;
                fetch <= fetch + {{(AW-1){1'b0}}, 1'b1};
                if (word[1:0] == `CSD_CLASS_HALT) begin
                    fetch <= fetch;
                    if (auto_mode) begin
                        program_finished <= 1'b1;
                    end
                    state <= ST_HALT;
                end else begin
                    state <= ST_PAY;
                end
            end
            ST_PAY: begin
                pay_idx <= csd_next(pay_mask, pay_idx);
                if (pay_mask[csd_next(pay_mask, pay_idx)]) begin
                    case (csd_next(pay_mask, pay_idx))
                        3'h0: current_target <= word;
                        3'h1: voltage_target <= word[15] ? rel_v
                            : word;
                        3'h2: power_target <= word;
                        3'h3: conductance_target <= word;
                        3'h4: current_end_level <= word;
                        3'h5: voltage_gate_level <= word[15] ? rel_v
                            : word;
                        3'h6: time_limit <= word;
                        default: begin
                            if (repeat_total == 8'h00) begin
                                repeat_total <= word[7:0];
                            end
                        end
                    endcase
                end
                fetch <= fetch + {{(AW-1){1'b0}}, 1'b1};
                pay_idx <= csd_next(pay_mask, pay_idx) + 3'h1;
                if (csd_next(pay_mask, pay_idx) == 3'h7
                        || pay_mask[7] == 1'b0
                        && csd_next(pay_mask, pay_idx) == 3'h6) begin
                    if (hdr[`CSD_H_RHEAD]) begin
                        head_addr <= pc;
                    end
                    tick_cnt <= 16'h0000;
                    time_cnt <= 16'h0000;
                    state <= ST_EXEC;
                end
            end
            ST_EXEC: begin
                // Time base: one count per tick period
                if (tick_cnt == TICK_CYCLES - 16'h1) begin
                    tick_cnt <= 16'h0000;
                    time_cnt <= time_cnt + 16'h1;
                end else begin
                    tick_cnt <= tick_cnt + 16'h1;
                end
                if (time_up) begin
                    if (hdr[`CSD_H_TFAULT]) begin
                        instr_timeout <= 1'b1;
                    end
                    if (hdr[`CSD_H_RTAIL] && repeat_total != 8'h01
                            && repeat_total != 8'h00) begin
                        repeat_total <= repeat_total - 8'h01;
                        pc <= head_addr;
                        fetch <= head_addr;
                    end else begin
                        if (hdr[`CSD_H_RTAIL] && repeat_total != 8'h00) begin
                            repeat_total <= 8'h00;
                        end
                        pc <= pc + {{(AW-1){1'b0}}, 1'b1}
                            + csd_count(pay_mask);
                        fetch <= pc + {{(AW-1){1'b0}}, 1'b1}
                            + csd_count(pay_mask);
                    end
                    state <= auto_mode ? ST_HDR : ST_IDLE;
                end
            end
            ST_HALT: state <= ST_HALT;
            ST_IDLE: state <= ST_IDLE;
            default: state <= ST_IDLE;
        endcase
    end
end

// ****************************************************************
// Outputs
// ****************************************************************
// Header fields and drive overrides, all registered
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        high_side_drive <= 1'b0;
        low_side_drive <= 1'b0;
        switch_pin_level <= 1'b0;
        loop_hold <= 1'b0;
        measure_run <= 1'b0;
        auto_async_rectify_en <= 1'b0;
        limit_check_off <= 1'b0;
        mode_flags <= 4'h0;
        discharge <= 1'b0;
        time_limit_is_fault <= 1'b0;
        loop_gain_bank <= 1'b0;
        voltage_source_sel <= 1'b0;
        ramp_en <= 1'b0;
        done_irq_req <= 1'b0;
    end else begin
        auto_async_rectify_en <= hdr[`CSD_H_ASYNC];
        limit_check_off <= hdr[`CSD_H_LIMOFF];
        mode_flags <= hdr[`CSD_H_RES:`CSD_H_VOLT];
        time_limit_is_fault <= hdr[`CSD_H_TFAULT];
        done_irq_req <= hdr[`CSD_H_IRQ];
        loop_gain_bank <= hdr[`CSD_H_GAIN];
        voltage_source_sel <= hdr[`CSD_H_VSRC];
        ramp_en <= hdr[`CSD_H_RAMP];
        switch_pin_level <= hdr[`CSD_H_SWITCH];
        measure_run <= (state == ST_EXEC);
        discharge <= instruction_class[1]
            && instruction_class != CHARGE_CODE;
        loop_hold <= (state == ST_EXEC)
            && instruction_class == `CSD_CLASS_REST;
        if (state == ST_EXEC && instruction_class[1]) begin
            high_side_drive <= loop_high_side;
            low_side_drive <= loop_low_side;
        end else begin
            high_side_drive <= 1'b0;
            low_side_drive <= 1'b0;
        end
    end
end

endmodule

// *** verification/csd_props.sv ***
// Concurrent checks on the sequencer decoder's ports.
// Assumes binding to csd_decoder, one clock and an active-low reset.
`timescale 1ns/1ps

// ****************************************************************
// Port checker
// ****************************************************************
module csd_props (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire loop_high_side,
    input wire loop_low_side,
    input wire high_side_drive,
    input wire low_side_drive,
    input wire loop_hold,
    input wire measure_run,
    input wire time_limit_is_fault,
    input wire program_finished,
    input wire instr_timeout
);
    reg dp_ctrl_wr;
    reg dp_stat_rd;
    wire start_wr = dp_ctrl_wr && hwdata[0];

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Remember which register the running data phase belongs to
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_ctrl_wr <= 1'b0;
            dp_stat_rd <= 1'b0;
        end else if (hready) begin
            dp_ctrl_wr <= hsel && htrans[1] && hwrite && haddr[7:0] == 8'h00;
            dp_stat_rd <= hsel && htrans[1] && !hwrite && haddr[7:0] == 8'h04;
        end
    end

    bus_okay_a: assert property ($past(hresetn) |-> hreadyout && !hresp)
        else $error("bus not ready or not okay");
    rest_drive_low_a: assert property (
        loop_hold |-> !high_side_drive && !low_side_drive)
        else $error("drive active during rest");
    rest_measure_a: assert property (loop_hold |-> measure_run)
        else $error("measurement stopped during rest");
    high_follow_a: assert property (
        high_side_drive |-> $past(loop_high_side))
        else $error("high drive not from loop");
    low_follow_a: assert property (
        low_side_drive |-> $past(loop_low_side))
        else $error("low drive not from loop");
    drive_exec_a: assert property (
        (high_side_drive || low_side_drive) |-> measure_run)
        else $error("drive active while not executing");
    finish_clear_a: assert property (
        program_finished ##1 !program_finished |-> $past(start_wr))
        else $error("finished flag dropped without start");
    timeout_clear_a: assert property (
        instr_timeout ##1 !instr_timeout |-> $past(start_wr))
        else $error("timeout flag dropped without start");
    timeout_fault_a: assert property (
        $rose(instr_timeout) |-> $past(time_limit_is_fault))
        else $error("timeout raised without fault bit");
    status_read_a: assert property (dp_stat_rd |->
        hrdata[5:4] == $past({instr_timeout, program_finished}))
        else $error("status read disagrees with flags");
endmodule

// *** verification/csd_host.sv ***
// Host model: loads instruction words and reaches registers.
// Assumes one AHB-Lite slave whose hreadyout is the bus ready.
`timescale 1ns/1ps

// ****************************************************************
// Host bus master
// ****************************************************************
module csd_host (
    input wire hclk,
    input wire hready,
    input wire [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // Idle bus from time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // One word transfer, entered and left just after a rising edge
    task bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
             output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask

    // Header then payload words, each in its own 16-bit location
    task load(input logic [6:0] base, input logic [15:0] w[$]);
        logic [31:0] q;
        bus(1'b1, 32'h08, {25'h0, base}, q);
        foreach (w[i]) bus(1'b1, 32'h0C, {16'h0, w[i]}, q);
    endtask
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the sequencer instruction decoder.
// Assumes csd_decoder, csd_host and csd_props compiled before it.
`timescale 1ns/1ps

// ****************************************************************
// Bench top
// ****************************************************************
module tb_top;
    typedef struct {
        logic [15:0] hdr;
        logic [15:0] pl [8];
        logic [31:0] tgt;
    } csd_row_t;
    logic hclk;
    logic hresetn;
    logic loop_high_side;
    logic loop_low_side;
    wire hsel, hwrite, hreadyout, hresp, high_side_drive, low_side_drive;
    wire switch_pin_level, loop_hold, measure_run, auto_async_rectify_en;
    wire limit_check_off, discharge, time_limit_is_fault, loop_gain_bank;
    wire voltage_source_sel, ramp_en, done_irq_req, program_finished;
    wire instr_timeout;
    wire [31:0] haddr, hwdata, hrdata;
    wire [1:0] htrans;
    wire [2:0] hsize;
    wire [3:0] mode_flags;
    wire [13:0] flags = {auto_async_rectify_en, limit_check_off, mode_flags,
        time_limit_is_fault, done_irq_req, loop_gain_bank, voltage_source_sel,
        switch_pin_level, ramp_en, loop_hold, discharge};
    int err_total = 0;
    int checks = 0;
    int n;
    logic prev;
    logic [31:0] q;
    logic [15:0] w [$];
    csd_row_t rows [4];

    csd_decoder #(.TICK_CYCLES(16'h0002)) dut_u (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .loop_high_side(loop_high_side), .loop_low_side(loop_low_side),
        .high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
        .switch_pin_level(switch_pin_level), .loop_hold(loop_hold),
        .measure_run(measure_run), .limit_check_off(limit_check_off),
        .auto_async_rectify_en(auto_async_rectify_en), .ramp_en(ramp_en),
        .mode_flags(mode_flags), .discharge(discharge),
        .time_limit_is_fault(time_limit_is_fault), .instr_timeout(instr_timeout),
        .loop_gain_bank(loop_gain_bank), .voltage_source_sel(voltage_source_sel),
        .done_irq_req(done_irq_req), .program_finished(program_finished));
    csd_host host_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));

    // Clock and a loop stand-in that changes every cycle
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        loop_high_side <= ~loop_high_side;
        loop_low_side <= loop_high_side;
    end

    // Payload length and header fields expected from a header word
    function automatic int plen(input logic [15:0] h);
        if (h[1:0] == 2'h0) return 0;
        if (h[1:0] == 2'h1) return 1 + h[10];
        return h[3] + h[2] + h[4] + h[5] + h[2] + h[3] + 1 + h[10];
    endfunction
    function automatic logic [31:0] expf(input logic [15:0] h);
        return {18'h0, h[7:2], h[15:12], h[9:8], h[1:0] == 2'h1,
            h[1:0] == 2'h3};
    endfunction

    // Comparison, bus shorthands and waits
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        host_u.bus(1'b1, {24'h0, a}, d, q);
    endtask
    task rd(input logic [7:0] a);
        host_u.bus(1'b0, {24'h0, a}, 32'h0, q);
    endtask
    task start(input logic [31:0] ctrl);
        host_u.load(7'h00, w);
        wr(8'h00, ctrl);
    endtask
    task wait_run(input logic lvl);
        int i;
        for (i = 0; i < 4000 && measure_run !== lvl; i++) @(posedge hclk);
        check(32'(i < 4000), 32'h1);
    endtask
    task tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (30000) @(posedge hclk);
        err_total++;
        $display("watchdog expired");
        tally_and_finish();
    end

    // Main sequence
    initial begin
        hresetn = 1'b0;
        loop_high_side = 1'b0;
        loop_low_side = 1'b0;
        rows[0] = '{16'h020E, '{16'h0123, 16'h0456, 16'h0010, 16'h0020,
            16'h0003, 16'h0, 16'h0, 16'h0}, 32'h04560123};
        rows[1] = '{16'h31FF, '{16'h0111, 16'h8005, 16'h2222, 16'h3333,
            16'h0001, 16'h8002, 16'h0002, 16'h0}, 32'h01050111};
        rows[2] = '{16'h4201, '{16'h0004, 16'h0, 16'h0, 16'h0,
            16'h0, 16'h0, 16'h0, 16'h0}, 32'h01050111};
        rows[3] = '{16'h000E, '{16'h7FFF, 16'h7FFF, 16'h0000, 16'h8001,
            16'h0001, 16'h0, 16'h0, 16'h0}, 32'h7FFF7FFF};
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(8'h04);
        check(q, 32'h0);
        rd(8'h20);
        check(q, 32'h0);
        wr(8'h14, 32'h0100);
        rd(8'h14);
        check(q, 32'h0100);
        foreach (rows[i]) begin
            w = {rows[i].hdr};
            for (int k = 0; k < plen(rows[i].hdr); k++) w.push_back(rows[i].pl[k]);
            start(32'h1);
            wait_run(1'b1);
            check(32'(flags), expf(rows[i].hdr));
            rd(8'h1C);
            check(32'(q[15:0]), 32'(w[w.size() - 1]));
            wait_run(1'b0);
            rd(8'h10);
            check(q, rows[i].tgt);
            rd(8'h18);
            check(32'(q[6:0]), 32'(plen(rows[i].hdr) + 1));
            rd(8'h04);
            check(32'(q[5:4]), 32'h0);
            $display("row test %0d done", i);
        end
        // Automatic loop of rest and charge, closed by a halt
        w = {16'h0401, 16'h0001, 16'hAB03, 16'h080E, 16'h0200, 16'h0300,
            16'h0001, 16'h0002, 16'h0001, 16'h0000};
        start(32'h3);
        n = 0;
        prev = 1'b0;
        for (int i = 0; i < 4000 && program_finished !== 1'b1; i++) begin
            @(posedge hclk);
            if (loop_hold === 1'b1 && prev !== 1'b1) n++;
            prev = loop_hold;
        end
        check(32'(n), 32'h3);
        check(32'({high_side_drive, low_side_drive}), 32'h0);
        repeat (10) @(posedge hclk);
        rd(8'h18);
        check(32'({q[23:16], q[6:0]}), 32'h9);
        rd(8'h04);
        check(32'(q[5:4]), 32'h1);
        wr(8'h00, 32'h1);
        rd(8'h04);
        check(32'(q[4]), 32'h0);
        wait_run(1'b0);
        $display("loop test done");
        // Rest flagged as fault, then a manual halt
        w = {16'h8001, 16'h0002};
        start(32'h1);
        wait_run(1'b1);
        wait_run(1'b0);
        rd(8'h04);
        check(32'(q[5:4]), 32'h2);
        w = {16'h0000};
        start(32'h1);
        repeat (8) @(posedge hclk);
        rd(8'h18);
        check(32'(q[6:0]), 32'h0);
        rd(8'h04);
        check(32'(q[5:4]), 32'h0);
        check(32'({high_side_drive, low_side_drive}), 32'h0);
        $display("timeout and halt test done");
        // Reset in the middle of a long charge
        w = {16'h020E, 16'h0001, 16'h0002, 16'h0001, 16'h0001, 16'h0040};
        start(32'h1);
        wait_run(1'b1);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        check(32'({hreadyout, measure_run, switch_pin_level}), 32'h0);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(8'h04);
        check(q, 32'h0);
        $display("reset test done");
        tally_and_finish();
    end
endmodule

bind csd_decoder csd_props chk_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .loop_high_side(loop_high_side),
    .loop_low_side(loop_low_side), .high_side_drive(high_side_drive),
    .low_side_drive(low_side_drive), .loop_hold(loop_hold),
    .measure_run(measure_run), .time_limit_is_fault(time_limit_is_fault),
    .program_finished(program_finished), .instr_timeout(instr_timeout));
